// [tsc_pkg.sv]
// Package for the throttle speed command shaper: offsets, fields, resets, timing
package tsc_pkg;
    // Register byte offsets
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_THR = 6'h04;
    localparam logic [5:0] OFS_M1SPD = 6'h08;
    localparam logic [5:0] OFS_M2SPD = 6'h0C;
    localparam logic [5:0] OFS_STATUS = 6'h10;
    localparam logic [5:0] OFS_MASK = 6'h14;
    localparam logic [5:0] OFS_STATE = 6'h18;
    // CTRL bit positions
    localparam int CTRL_TYPE_LSB = 0;
    localparam int CTRL_SLP_EN = 4;
    localparam int CTRL_LOCK_EN = 5;
    localparam int CTRL_NEUT_EN = 6;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0022;
    localparam logic [31:0] THR_RST = 32'h0A5A_0033;
    localparam logic [31:0] SPD_RST = 32'h3264_3264;
    // Voltage limits in ADC codes, 8-bit over 0..5 V, then deadband and full-scale limits in percent
    localparam logic [7:0] HI_MIN = 8'h99;
    localparam logic [7:0] LO_MAX = 8'h66;
    localparam logic [7:0] PCT_MIN_DB = 8'h05;
    localparam logic [7:0] PCT_MAX_DB = 8'h1E;
    localparam logic [7:0] PCT_MIN_FS = 8'h28;
    localparam logic [7:0] PCT_FULL = 8'h64;
    // Lockout timing
    localparam int CLK_HZ = 125_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int LOCK_S = 10;
    localparam int LOCK_TICKS = LOCK_S * 1000;
    // Status bit positions
    localparam int ST_LOCK = 0;
    localparam int ST_FAULT = 1;
    localparam int ST_NEUT = 2;

    typedef struct packed {
        logic [7:0] top;
        logic [7:0] bottom;
        logic [7:0] revTop;
        logic [7:0] revBottom;
    } tsc_spd_t;

    typedef struct packed {
        logic [15:0] cmd;
        logic rev;
        logic drive;
    } tsc_cmd_t;

    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_HELD = 2'b01,
        LK_FAULT = 2'b11
    } tsc_lk_t;
endpackage : tsc_pkg

// [tsc_shaper.sv]
// Throttle speed command shaper with Avalon-MM register slave
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
module tsc_shaper
    import tsc_pkg::*;
#(
    parameter int LockTicks = LOCK_TICKS,
    // Cycles per lockout tick; shortened only in simulation
    parameter int TickCyc = TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Operator inputs from pins
    input wire logic [7:0] throttleAdc,
    input wire logic [7:0] limitPotAdc,
    input wire logic modeIn,
    input wire logic neutralIn,
    // Avalon-MM slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Results
    output tsc_pkg::tsc_cmd_t speedCmd,
    output logic wiringFault,
    output logic irq
);
    import tsc_pkg::*;

    // Two-stage pin synchronisers
    logic [7:0] thrS1_r, thrS2_r, limS1_r, limS2_r;
    logic modeS1_r, modeS2_r, neutS1_r, neutS2_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            thrS1_r <= 8'h00;
            thrS2_r <= 8'h00;
            limS1_r <= 8'h00;
            limS2_r <= 8'h00;
            modeS1_r <= 1'b0;
            modeS2_r <= 1'b0;
            neutS1_r <= 1'b0;
            neutS2_r <= 1'b0;
        end else if (clkEn) begin
            thrS1_r <= throttleAdc;
            thrS2_r <= thrS1_r;
            limS1_r <= limitPotAdc;
            limS2_r <= limS1_r;
            modeS1_r <= modeIn;
            modeS2_r <= modeS1_r;
            neutS1_r <= neutralIn;
            neutS2_r <= neutS1_r;
        end
    end

    // Registers
    logic [31:0] ctrl_r, ctrl_nxt, thr_r, thr_nxt, status_r, status_nxt, mask_r, mask_nxt;
    tsc_spd_t m1_r, m1_nxt, m2_r, m2_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;
    logic [2:0] evt;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) res[i*8 +: 8] = nw[i*8 +: 8];
        end
        return res;
    endfunction : merge

    logic req, wr;
    assign req = (read | write) & !ack_r;
    // A write commits at the edge where waitrequest is seen low
    assign wr = write & ack_r;

    tsc_lk_t lk_r, lk_nxt;

    always_comb begin
        ctrl_nxt = ctrl_r;
        thr_nxt = thr_r;
        m1_nxt = m1_r;
        m2_nxt = m2_r;
        mask_nxt = mask_r;
        rdata_nxt = rdata_r;
        ack_nxt = req;
        status_nxt = status_r;
        if (wr) begin
            if (address == OFS_CTRL) begin
                ctrl_nxt = merge(ctrl_r, writedata, byteenable) & 32'h0000_007F;
            end else if (address == OFS_THR) begin
                thr_nxt = merge(thr_r, writedata, byteenable);
            end else if (address == OFS_M1SPD) begin
                m1_nxt = merge(m1_r, writedata, byteenable);
            end else if (address == OFS_M2SPD) begin
                m2_nxt = merge(m2_r, writedata, byteenable);
            end else if (address == OFS_STATUS) begin
                status_nxt = status_r & ~(writedata & {{8{byteenable[3]}}, {8{byteenable[2]}},
                                          {8{byteenable[1]}}, {8{byteenable[0]}}});
            end else if (address == OFS_MASK) begin
                mask_nxt = merge(mask_r, writedata, byteenable) & 32'h0000_0007;
            end
        end
        // Set wins over a simultaneous clear
        status_nxt = status_nxt | {29'h0, evt};
        if (read & req) begin
            if (address == OFS_CTRL) rdata_nxt = ctrl_r;
            else if (address == OFS_THR) rdata_nxt = thr_r;
            else if (address == OFS_M1SPD) rdata_nxt = m1_r;
            else if (address == OFS_M2SPD) rdata_nxt = m2_r;
            else if (address == OFS_STATUS) rdata_nxt = status_r;
            else if (address == OFS_MASK) rdata_nxt = mask_r;
            else if (address == OFS_STATE) rdata_nxt = {12'h0, lk_r, speedCmd};
            else rdata_nxt = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RST;
            thr_r <= THR_RST;
            m1_r <= SPD_RST;
            m2_r <= SPD_RST;
            status_r <= 32'h0000_0000;
            mask_r <= 32'h0000_0000;
            rdata_r <= 32'h0000_0000;
            ack_r <= 1'b0;
        end else if (clkEn) begin
            ctrl_r <= ctrl_nxt;
            thr_r <= thr_nxt;
            m1_r <= m1_nxt;
            m2_r <= m2_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end
    assign readdata = rdata_r;
    // Answer one cycle after the request is seen
    assign waitrequest = !ack_r;

    // Settings, clamped into their printed ranges
    logic [3:0] thrType;
    logic slpEn, lockEn, neutEn;
    logic [7:0] dbPct, fsPct, hiLim, loLim;
    assign thrType = ctrl_r[CTRL_TYPE_LSB +: 4];
    assign slpEn = ctrl_r[CTRL_SLP_EN];
    assign lockEn = ctrl_r[CTRL_LOCK_EN];
    assign neutEn = ctrl_r[CTRL_NEUT_EN];
    always_comb begin
        dbPct = thr_r[7:0] < PCT_MIN_DB ? PCT_MIN_DB : (thr_r[7:0] > PCT_MAX_DB ? PCT_MAX_DB : thr_r[7:0]);
        fsPct = thr_r[15:8] < PCT_MIN_FS ? PCT_MIN_FS : (thr_r[15:8] > PCT_FULL ? PCT_FULL : thr_r[15:8]);
        hiLim = thr_r[23:16] < HI_MIN ? HI_MIN : thr_r[23:16];
        loLim = thr_r[31:24] > LO_MAX ? LO_MAX : thr_r[31:24];
    end

    // Throttle decode: signed deflection in percent, positive is forward
    logic [7:0] lo, hi, span, pos, posPct;
    logic [8:0] defl;
    logic signed [9:0] sdefl;
    logic [7:0] mag;
    logic isRev, inNeutral;
    always_comb begin
        lo = (thrType >= 4'h5) ? loLim : 8'h00;
        hi = (thrType >= 4'h5) ? hiLim : 8'hFF;
        span = hi - lo;
        pos = (thrS2_r <= lo) ? 8'h00 : ((thrS2_r >= hi) ? span : 8'(thrS2_r - lo));
        posPct = (span == 8'h00) ? 8'h00 : 8'((16'(pos) * 16'(PCT_FULL)) / 16'(span));
        sdefl = 10'sd0;
        case (thrType)
            4'h0, 4'h5: sdefl = 10'(signed'({2'b00, posPct}) * 2 - 100);
            4'h1, 4'h6: sdefl = 10'(100 - signed'({2'b00, posPct}) * 2);
            4'h2, 4'h7: sdefl = 10'(signed'({2'b00, posPct}));
            4'h3, 4'h8: sdefl = 10'(100 - signed'({2'b00, posPct}));
            4'h4, 4'h9: sdefl = 10'(signed'({2'b00, posPct}) * 2 - 100);
            default: sdefl = 10'sd0;
        endcase
        isRev = sdefl < 0;
        defl = isRev ? 9'(-sdefl) : 9'(sdefl);
        if (defl > 9'd100) defl = 9'd100;
        inNeutral = defl <= 9'(dbPct);
        // Scale band edge to full-scale point; larger setting means less stroke
        if (inNeutral) mag = 8'h00;
        else if (defl >= 9'(PCT_FULL - (fsPct - PCT_MIN_FS)) || fsPct == PCT_FULL) mag = PCT_FULL;
        else mag = 8'((16'(defl - 9'(dbPct)) * 16'(PCT_FULL)) /
                      16'(PCT_FULL - (fsPct - PCT_MIN_FS) - dbPct));
    end

    // Speed limits per mode and direction
    tsc_spd_t sel;
    logic [7:0] top, bot, lim, limPct;
    always_comb begin
        sel = modeS2_r ? m2_r : m1_r;
        top = isRev ? sel.revTop : sel.top;
        bot = isRev ? sel.revBottom : sel.bottom;
        if (bot > top) bot = top;
        limPct = 8'((16'(limS2_r) * 16'(PCT_FULL)) / 16'hFF);
        if (slpEn) lim = 8'(16'(bot) + (16'(top - bot) * 16'(limPct)) / 16'(PCT_FULL));
        else lim = top;
    end

    // Powerup lockout
    logic [16:0] tickCnt_r, tickCnt_nxt;
    logic [15:0] lkCnt_r, lkCnt_nxt;
    logic first_r, first_nxt, neutBlock;
    // Powerup sample waits until the pin synchronisers hold real pin values
    logic [1:0] pwrCnt_r, pwrCnt_nxt;
    logic syncFull;
    assign syncFull = (pwrCnt_r == 2'd2);
    tsc_cmd_t cmd_r, cmd_nxt;
    logic fault_r, fault_nxt, irq_r, irq_nxt;
    assign neutBlock = neutEn & neutS2_r;
    always_comb begin
        lk_nxt = lk_r;
        first_nxt = first_r & !syncFull;
        pwrCnt_nxt = syncFull ? pwrCnt_r : pwrCnt_r + 2'd1;
        tickCnt_nxt = (tickCnt_r == 17'(TickCyc - 1)) ? 17'h0 : tickCnt_r + 17'h1;
        lkCnt_nxt = lkCnt_r;
        evt = 3'b000;
        case (lk_r)
            LK_IDLE: begin
                if (first_r && syncFull && lockEn && !inNeutral) begin
                    lk_nxt = LK_HELD;
                    evt[ST_LOCK] = 1'b1;
                end
            end
            LK_HELD: begin
                if (inNeutral) begin
                    lk_nxt = LK_IDLE;
                    lkCnt_nxt = 16'h0;
                end else if (tickCnt_r == 17'h0) begin
                    lkCnt_nxt = lkCnt_r + 16'h1;
                    if (lkCnt_r == 16'(LockTicks - 1)) begin
                        lk_nxt = LK_FAULT;
                        evt[ST_FAULT] = 1'b1;
                    end
                end
            end
            LK_FAULT: lk_nxt = LK_FAULT;
            default: lk_nxt = LK_IDLE;
        endcase
        if (neutBlock && !inNeutral) evt[ST_NEUT] = 1'b1;
        cmd_nxt.rev = isRev;
        cmd_nxt.drive = (lk_nxt == LK_IDLE) && !inNeutral && !neutBlock && !first_r;
        cmd_nxt.cmd = cmd_nxt.drive ? 16'(lim) * 16'(mag) : 16'h0;
        fault_nxt = (lk_nxt == LK_FAULT);
        irq_nxt = |(status_nxt[2:0] & mask_r[2:0]);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lk_r <= LK_IDLE;
            first_r <= 1'b1;
            pwrCnt_r <= 2'd0;
            tickCnt_r <= 17'h0;
            lkCnt_r <= 16'h0;
            cmd_r <= '0;
            fault_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (clkEn) begin
            lk_r <= lk_nxt;
            first_r <= first_nxt;
            pwrCnt_r <= pwrCnt_nxt;
            tickCnt_r <= tickCnt_nxt;
            lkCnt_r <= lkCnt_nxt;
            cmd_r <= cmd_nxt;
            fault_r <= fault_nxt;
            irq_r <= irq_nxt;
        end
    end
    assign speedCmd = cmd_r;
    assign wiringFault = fault_r;
    assign irq = irq_r;
endmodule : tsc_shaper

// [tsc_checker.sv]
// Port assertions for the throttle speed command shaper
`timescale 1ns/1ns
module tsc_checker
    import tsc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Bus
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Results
    input wire tsc_pkg::tsc_cmd_t speedCmd,
    input wire logic wiringFault,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_one_wait: assert property (clkEn && (read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait state");
    a_no_spurious: assert property (clkEn && !(read || write) |=> waitrequest)
        else $error("answer without a request");
    a_read_hold: assert property (waitrequest |-> $stable(readdata))
        else $error("read data moved outside an answer");
    a_cmd_bound: assert property (speedCmd.cmd <= 16'd10000)
        else $error("speed command above full scale");
    a_fault_latch: assert property (wiringFault |=> wiringFault)
        else $error("wiring fault released without reset");
    a_fault_nodrive: assert property (wiringFault |-> !speedCmd.drive)
        else $error("drive while wiring fault");
    a_fault_late: assert property ($rose(rst_n) |-> !wiringFault [*8])
        else $error("wiring fault before lockout interval");
    a_reset_quiet: assert property ($rose(rst_n) && $past(clkEn) |-> speedCmd == '0 && !irq)
        else $error("outputs active right after reset");
    a_freeze: assert property (!clkEn |=> $stable(speedCmd) && $stable(wiringFault))
        else $error("state moved while clock enable low");
endmodule : tsc_checker

bind tsc_shaper tsc_checker tsc_checker_i (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .speedCmd(speedCmd), .wiringFault(wiringFault), .irq(irq));

// [tsc_operator.sv]
// Operator side model: throttle, speed limit pot, mode and neutral switches
`timescale 1ns/1ns
module tsc_operator (
    // Clock
    input wire logic clk,
    // Requested positions
    input wire logic [7:0] thrSet,
    input wire logic [7:0] potSet,
    input wire logic modeSet,
    input wire logic neutSet,
    // Pins
    output logic [7:0] throttleAdc = 8'h00,
    output logic [7:0] limitPotAdc = 8'h00,
    output logic modeIn = 1'b0,
    output logic neutralIn = 1'b0
);
    // Pins move only at an edge so the synchroniser latency is repeatable
    always @(posedge clk) begin
        throttleAdc <= thrSet;
        limitPotAdc <= potSet;
        modeIn <= modeSet;
        neutralIn <= neutSet;
    end
endmodule : tsc_operator

// [testbench.sv]
// Self-checking testbench for the throttle speed command shaper
`timescale 1ns/1ns
module testbench;
    import tsc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [5:0] address = 6'h00;
    logic [31:0] writedata = 32'h0;
    logic [7:0] thrSet = 8'h00;
    logic [7:0] potSet = 8'h00;
    logic modeSet = 1'b0;
    logic neutSet = 1'b0;
    logic clkEn = 1'b1;
    // Short lockout timing keeps the run small
    localparam int TB_TICK = 20;
    localparam int TB_LOCK = 3;
    logic [7:0] throttleAdc, limitPotAdc;
    logic modeIn, neutralIn, waitrequest, wiringFault, irq;
    logic [31:0] readdata, q;
    tsc_cmd_t speedCmd;
    int fail_count = 0;
    int total_checks = 0;
    int n;
    // Type, pin code, reverse, drive for each full deflection or neutral case
    logic [15:0] tbl [15] = '{16'h0FF1, 16'h1001, 16'h0003, 16'h1FF3, 16'h2FF1, 16'h3001, 16'h5FF1, 16'h6001,
        16'h7FF1, 16'h8001, 16'h2000, 16'h3FF0, 16'h7000, 16'h8FF0, 16'h0800};

    always #4 clk = ~clk;

    tsc_operator tsc_operator_i (.clk(clk), .thrSet(thrSet), .potSet(potSet), .modeSet(modeSet), .neutSet(neutSet),
        .throttleAdc(throttleAdc), .limitPotAdc(limitPotAdc), .modeIn(modeIn), .neutralIn(neutralIn));
    tsc_shaper #(.LockTicks(TB_LOCK), .TickCyc(TB_TICK)) tsc_shaper_i (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
        .throttleAdc(throttleAdc),
        .limitPotAdc(limitPotAdc), .modeIn(modeIn), .neutralIn(neutralIn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .speedCmd(speedCmd), .wiringFault(wiringFault), .irq(irq));

    task automatic conclude;
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Direction is only meaningful while driving, so it is masked in neutral
    task automatic chk(input int pct, input logic rev, input logic drv);
        check({14'h0, speedCmd.cmd, speedCmd.rev & speedCmd.drive, speedCmd.drive}, {14'h0, 16'(pct * 100), rev, drv});
    endtask : chk

    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 20);
        q = readdata;
        if (k >= 20)
            fail_count++;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic pins(input logic [7:0] t, input logic [7:0] p, input logic m, input logic u);
        thrSet <= t;
        potSet <= p;
        modeSet <= m;
        neutSet <= u;
        repeat (10) @(posedge clk);
    endtask : pins

    task automatic pulse;
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : pulse

    initial begin
        void'($urandom(32'h79876EF9));
        pulse();
        bus(0, OFS_CTRL, 0); check(q, CTRL_RST);
        bus(0, OFS_THR, 0); check(q, THR_RST);
        bus(0, OFS_M2SPD, 0); check(q, SPD_RST);
        bus(0, 6'h1C, 0); check(q, 32'h0);
        pins(8'hFF, 8'h00, 0, 0); chk(50, 0, 1);
        bus(1, OFS_M2SPD, 32'h5014_3C0A);
        pins(8'hFF, 8'h00, 1, 0); chk(80, 0, 1);
        bus(1, OFS_CTRL, 32'h32);
        pins(8'hFF, 8'h00, 0, 0); chk(50, 0, 1);
        pins(8'hFF, 8'h00, 1, 0); chk(20, 0, 1);
        pins(8'hFF, 8'hFF, 1, 0); chk(80, 0, 1);
        bus(1, OFS_CTRL, 32'h30);
        pins(8'h00, 8'h00, 1, 0); chk(10, 1, 1);
        // Full scale at 100 opens full output just outside a 5 percent band
        bus(1, OFS_THR, 32'h0A99_6405);
        for (int i = 0; i < 15; i++) begin
            bus(1, OFS_CTRL, {28'h0000003, tbl[i][15:12]});
            pins(tbl[i][11:4], 8'hFF, 1, 0);
            chk(tbl[i][0] ? (tbl[i][1] ? 60 : 80) : 0, tbl[i][1], tbl[i][0]);
        end
        bus(1, OFS_CTRL, 32'h32);
        pins(8'h20, 8'hFF, 1, 0); chk(80, 0, 1);
        clkEn <= 1'b0;
        pins(8'h00, 8'hFF, 1, 0); chk(80, 0, 1);
        clkEn <= 1'b1;
        repeat (4) begin
            pins(8'($urandom_range(9, 0)), 8'($urandom), 1, 0); chk(0, 0, 0);
        end
        bus(1, OFS_CTRL, 32'h72);
        pins(8'hFF, 8'hFF, 1, 1); chk(0, 0, 0);
        bus(0, OFS_STATUS, 0); check(q[2], 1'b1);
        pins(8'hFF, 8'hFF, 1, 0); chk(80, 0, 1);
        pulse();
        chk(0, 0, 0);
        bus(1, OFS_MASK, 32'h1);
        bus(0, OFS_STATUS, 0); check(q[0], 1'b1);
        repeat (2) @(posedge clk);
        check(irq, 1'b1);
        bus(1, OFS_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        pins(8'h00, 8'hFF, 1, 0); chk(0, 0, 0);
        pins(8'hFF, 8'hFF, 1, 0); chk(50, 0, 1);
        pulse();
        n = 0;
        while (wiringFault !== 1'b1 && n < (TB_LOCK + 1) * TB_TICK) begin
            @(posedge clk);
            n++;
        end
        check(wiringFault, 1'b1);
        check(n >= (TB_LOCK - 1) * TB_TICK, 1'b1);
        pins(8'h00, 8'hFF, 1, 0); chk(0, 0, 0);
        check(wiringFault, 1'b1);
        bus(0, OFS_STATE, 0); check(q[19:18], 2'b11);
        conclude();
    end

    initial begin
        #(8 * 20000);
        fail_count++;
        conclude();
    end
endmodule : testbench
